// ===== rtl/rtcsp_serial_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Time and calendar registers count in BCD digits.
// - Month end follows month length; every year divisible by four is leap, 2100 included.
// - Thirty-one scratch bytes plus timekeeping and control registers.
// - Answer only when the received 7-bit identifier matches ours.
// - General call identifier is never acknowledged nor acted on.
// - Single transfer is identifier, address/command, then one data byte.
// - Start is data falling with clock high; stop is data rising.
// - Data driven stays stable while clock is high; one bit per pulse.
// - Any start abandons the transfer; next byte is an identifier.
// - Slave only: clock is input, data line driven open-drain.
// - Unlimited bytes per frame; receiver acknowledges every byte.
// - Acknowledger holds data low through the acknowledge high phase.
// - No master acknowledge ends a read; device releases the data line.
// - Stop during a byte discards the partial byte.
// - Second byte is address/command; top bit zero blocks writes.
// - Command bit 6 picks clock registers (0) or scratch memory (1).
// - Command bits 5 to 1 are the register or memory index.
// - Command bit 0 selects write (0) or read (1).
// - Command byte shifts in most significant bit first.
// - Timekeeping read latches counters at command acknowledge, avoiding ticks.
module rtcsp_serial_slave #(
   parameter logic [6:0] SLAVE_ID = 7'h2A, // Arbitrary value
   parameter int RAM_DEPTH = 31
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Two-wire bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Seconds toggle from the oscillator domain
   input wire logic secToggle,
   // Status
   output rtcsp_pkg::rtcsp_time_t timeNow,
   output logic busBusy,
   output logic writeProtect
);
   import rtcsp_pkg::*;

   logic [1:0] sclSync_reg, sdaSync_reg, secSync_reg;
   logic sclLast_reg, sdaLast_reg, secLast_reg;
   rtcsp_state_t state_reg, state_next;
   logic [3:0] bitCnt_reg, bitCnt_next;
   logic [7:0] shift_reg, tx_reg, tx_next;
   logic [4:0] idx_reg, idx_next;
   logic sdaOe_reg, sdaOe_next;
   logic space_reg, space_next, dirRd_reg, dirRd_next;
   logic wrOk_reg, wrOk_next, mAck_reg, mAck_next;
   logic [7:0] calData, ramData;
   rtcsp_wr_t calWr;

   // Pins pass two flops; only the second stage feeds logic
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclSync_reg <= 2'h3;
         sdaSync_reg <= 2'h3;
         secSync_reg <= 2'h0;
         sclLast_reg <= 1'b1;
         sdaLast_reg <= 1'b1;
         secLast_reg <= 1'b0;
      end else begin
         sclSync_reg <= {sclSync_reg[0], sclIn};
         sdaSync_reg <= {sdaSync_reg[0], sdaIn};
         secSync_reg <= {secSync_reg[0], secToggle};
         sclLast_reg <= sclSync_reg[1];
         sdaLast_reg <= sdaSync_reg[1];
         secLast_reg <= secSync_reg[1];
      end
   end

   // Bus event decode
   wire sclNow = sclSync_reg[1];
   wire sdaNow = sdaSync_reg[1];
   wire startDet = sclNow && sclLast_reg && sdaLast_reg && !sdaNow;
   wire stopDet = sclNow && sclLast_reg && !sdaLast_reg && sdaNow;
   wire sclRise = sclNow && !sclLast_reg;
   wire sclFall = !sclNow && sclLast_reg;
   wire secTick = secSync_reg[1] ^ secLast_reg;

   // Byte framing and address decode
   wire rxState = state_reg == ST_SID || state_reg == ST_CMD || state_reg == ST_WDAT;
   wire countState = rxState || state_reg == ST_RDAT;
   wire byteEnd = sclFall && bitCnt_reg == BYTE_BITS;
   wire idMatch = shift_reg[7:1] == SLAVE_ID;
   wire genCall = shift_reg[7:1] == GEN_CALL_ID;
   wire readCmd = shift_reg[CMD_DIR_BIT];
   wire [7:0] rdByte = space_reg ? ramData : calData;

   // Write routing; protect bit leaves only control and scratch writable
   wire wrStrobe = state_reg == ST_WDAT && byteEnd && wrOk_reg;
   wire wpSet = timeNow.ctl[WP_BIT];
   wire calWrite = wrStrobe && !space_reg && (!wpSet || idx_reg == IDX_CTL);
   wire ramWrite = wrStrobe && space_reg;
   wire capPulse = state_reg == ST_CMD && byteEnd && readCmd && !shift_reg[CMD_SPACE_BIT];
   assign calWr = '{calWrite, idx_reg, shift_reg};

   // Serial engine; start and stop override any state
   always_comb begin
      state_next = state_reg;
      bitCnt_next = bitCnt_reg;
      sdaOe_next = sdaOe_reg;
      tx_next = tx_reg;
      idx_next = idx_reg;
      space_next = space_reg;
      dirRd_next = dirRd_reg;
      wrOk_next = wrOk_reg;
      mAck_next = mAck_reg;
      if (countState && sclRise) begin
         bitCnt_next = bitCnt_reg + 4'h1;
      end
      if (startDet) begin
         state_next = ST_SID;
         bitCnt_next = 4'h0;
         sdaOe_next = 1'b0;
      end else if (stopDet) begin
         state_next = ST_IDLE;
         bitCnt_next = 4'h0;
         sdaOe_next = 1'b0;
      end else begin
         case (state_reg)
            ST_SID: begin
               if (byteEnd) begin
                  bitCnt_next = 4'h0;
                  if (idMatch && !genCall) begin
                     state_next = ST_SACK;
                     sdaOe_next = 1'b1;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_SACK: begin
               if (sclFall) begin
                  if (shift_reg[0]) begin
                     state_next = ST_RDAT;
                     tx_next = rdByte;
                     sdaOe_next = !rdByte[7];
                  end else begin
                     state_next = ST_CMD;
                     sdaOe_next = 1'b0;
                  end
               end
            end
            ST_CMD: begin
               if (byteEnd) begin
                  state_next = ST_CACK;
                  bitCnt_next = 4'h0;
                  sdaOe_next = 1'b1;
                  wrOk_next = shift_reg[CMD_MUST_BIT];
                  space_next = shift_reg[CMD_SPACE_BIT];
                  idx_next = shift_reg[5:1];
                  dirRd_next = readCmd;
               end
            end
            ST_CACK: begin
               if (sclFall) begin
                  if (dirRd_reg) begin
                     state_next = ST_RDAT;
                     tx_next = rdByte;
                     sdaOe_next = !rdByte[7];
                  end else begin
                     state_next = ST_WDAT;
                     sdaOe_next = 1'b0;
                  end
               end
            end
            ST_WDAT: begin
               if (byteEnd) begin
                  state_next = ST_WACK;
                  bitCnt_next = 4'h0;
                  sdaOe_next = 1'b1;
                  idx_next = idx_reg + 5'h01;
               end
            end
            ST_WACK: begin
               if (sclFall) begin
                  state_next = ST_WDAT;
                  sdaOe_next = 1'b0;
               end
            end
            ST_RDAT: begin
               if (byteEnd) begin
                  state_next = ST_RACK;
                  bitCnt_next = 4'h0;
                  sdaOe_next = 1'b0;
                  idx_next = idx_reg + 5'h01;
               end else if (sclFall) begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  sdaOe_next = !tx_reg[6];
               end
            end
            ST_RACK: begin
               if (sclRise) begin
                  mAck_next = sdaNow;
               end
               if (sclFall) begin
                  if (!mAck_reg) begin
                     state_next = ST_RDAT;
                     tx_next = rdByte;
                     sdaOe_next = !rdByte[7];
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // Engine registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'hFF;
         idx_reg <= 5'h00;
         sdaOe_reg <= 1'b0;
         space_reg <= 1'b0;
         dirRd_reg <= 1'b0;
         wrOk_reg <= 1'b0;
         mAck_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         tx_reg <= tx_next;
         idx_reg <= idx_next;
         sdaOe_reg <= sdaOe_next;
         space_reg <= space_next;
         dirRd_reg <= dirRd_next;
         wrOk_reg <= wrOk_next;
         mAck_reg <= mAck_next;
         if (rxState && sclRise) begin
            shift_reg <= {shift_reg[6:0], sdaNow};
         end
      end
   end

   // Open-drain: only ever pull low; clock never driven
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_reg;
   assign busBusy = state_reg != ST_IDLE;
   assign writeProtect = wpSet;

   rtcsp_calendar u_cal (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .secTick(secTick),
      .wr(calWr),
      .capture(capPulse),
      .rdIdx(idx_reg),
      .rdData(calData),
      .timeNow(timeNow)
   );

   rtcsp_scratch_ram #(.DEPTH(RAM_DEPTH), .WIDTH(8)) u_ram (
      .sys_clk(sys_clk),
      .we(ramWrite),
      .addr(idx_reg),
      .wdata(shift_reg),
      .rdata(ramData)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_id_done;
      state_reg == ST_SID && byteEnd && !startDet && !stopDet;
   endsequence
   a_start_restart: assert property (startDet |=> state_reg == ST_SID && bitCnt_reg == 4'h0)
      else $error("start did not restart framing");
   a_stop_release: assert property (stopDet |=> state_reg == ST_IDLE && !sdaOe)
      else $error("stop did not release bus");
   a_id_ack: assert property (s_id_done and idMatch |=> state_reg == ST_SACK && sdaOe)
      else $error("own identifier not acknowledged");
   a_gencall_ignore: assert property (s_id_done and genCall |=> state_reg == ST_IDLE && !sdaOe)
      else $error("general call acknowledged");
   a_foreign_id: assert property (s_id_done and !idMatch |=> !sdaOe [*2])
      else $error("foreign identifier drove data line");
   a_oe_at_fall: assert property ($rose(sdaOe) |-> $past(sclFall))
      else $error("data line changed outside clock low");
   a_msb_first: assert property (rxState && sclRise && !startDet && !stopDet
      |=> shift_reg[0] == $past(sdaNow))
      else $error("bit order wrong");
   a_nack_release: assert property (state_reg == ST_RACK && sclFall && mAck_reg && !stopDet
      |=> state_reg == ST_IDLE && !sdaOe)
      else $error("no release after master nack");
   a_write_gate: assert property (calWrite || ramWrite |-> wrOk_reg && $past(state_reg) == ST_WDAT)
      else $error("write with top command bit clear");
   a_snap_cmd: assert property (capPulse |=> state_reg == ST_CACK && dirRd_reg && !space_reg)
      else $error("latch outside timekeeping read");
endmodule : rtcsp_serial_slave
`default_nettype wire

// ===== rtl/rtcsp_pkg.sv
package rtcsp_pkg;
   // Serial framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int CMD_MUST_BIT = 7;
   localparam int CMD_SPACE_BIT = 6;
   localparam int CMD_DIR_BIT = 0;
   localparam logic [6:0] GEN_CALL_ID = 7'h00;
   // Timekeeping register indices
   localparam logic [4:0] IDX_SEC = 5'h00;
   localparam logic [4:0] IDX_MIN = 5'h01;
   localparam logic [4:0] IDX_HR = 5'h02;
   localparam logic [4:0] IDX_DATE = 5'h03;
   localparam logic [4:0] IDX_MON = 5'h04;
   localparam logic [4:0] IDX_DAY = 5'h05;
   localparam logic [4:0] IDX_YR = 5'h06;
   localparam logic [4:0] IDX_CTL = 5'h07;
   localparam logic [4:0] IDX_CENT = 5'h09;
   // Control register write-protect bit
   localparam int WP_BIT = 7;
   localparam logic [7:0] CTL_MASK = 8'h80;
   // BCD limits
   localparam logic [7:0] SEC_MAX = 8'h59;
   localparam logic [7:0] HR_MAX = 8'h23;
   localparam logic [7:0] DAY_MAX = 8'h07;
   localparam logic [7:0] MON_MAX = 8'h12;
   localparam logic [7:0] MON_FEB = 8'h02;
   localparam logic [7:0] YR_MAX = 8'h99;
   localparam logic [7:0] FIRST_ONE = 8'h01;
   localparam logic [7:0] LAST_28 = 8'h28;
   localparam logic [7:0] LAST_29 = 8'h29;
   localparam logic [7:0] LAST_30 = 8'h30;
   localparam logic [7:0] LAST_31 = 8'h31;
   // Values after reset
   localparam logic [7:0] YR_POR = 8'h70;
   localparam logic [7:0] CENT_POR = 8'h19;
   // Serial engine states, Gray along the usual path
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SID = 4'h1,
      ST_SACK = 4'h3,
      ST_CMD = 4'h2,
      ST_CACK = 4'h6,
      ST_WDAT = 4'h7,
      ST_WACK = 4'h5,
      ST_RDAT = 4'h4,
      ST_RACK = 4'hC
   } rtcsp_state_t;
   // Timekeeping register set
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hr;
      logic [7:0] date;
      logic [7:0] mon;
      logic [7:0] day;
      logic [7:0] yr;
      logic [7:0] ctl;
      logic [7:0] cent;
   } rtcsp_time_t;
   // Register write request
   typedef struct packed {
      logic en;
      logic [4:0] idx;
      logic [7:0] data;
   } rtcsp_wr_t;
endpackage : rtcsp_pkg

// ===== rtl/rtcsp_scratch_ram.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsp_scratch_ram #(
   parameter int DEPTH = 31,
   parameter int WIDTH = 8
) (
   // Clock
   input wire logic sys_clk,
   // Access port
   input wire logic we,
   input wire logic [4:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   wire inRange = 32'(addr) < DEPTH;

   // Registered read; out of range reads as zero
   always_ff @(posedge sys_clk) begin
      if (we && inRange) begin
         mem[addr] <= wdata;
      end
      rdata <= inRange ? mem[addr] : '0;
   end
endmodule : rtcsp_scratch_ram
`default_nettype wire

// ===== rtl/rtcsp_calendar.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsp_calendar (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Counting and access
   input wire logic secTick,
   input wire rtcsp_pkg::rtcsp_wr_t wr,
   input wire logic capture,
   input wire logic [4:0] rdIdx,
   output logic [7:0] rdData,
   output rtcsp_pkg::rtcsp_time_t timeNow
);
   import rtcsp_pkg::*;

   rtcsp_time_t live_reg, live_next, snap_reg;
   logic pend_reg;
   logic [7:0] rdData_next;

   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction : bcdInc

   // Leap test in BCD and month length
   wire leap = v4(live_reg.yr);
   function automatic logic v4(input logic [7:0] y);
      v4 = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
   endfunction : v4
   wire short = live_reg.mon == 8'h04 || live_reg.mon == 8'h06 ||
                live_reg.mon == 8'h09 || live_reg.mon == 8'h11;
   wire [7:0] lastDay = (live_reg.mon == MON_FEB) ? (leap ? LAST_29 : LAST_28)
                      : (short ? LAST_30 : LAST_31);
   wire secWrap = live_reg.sec == SEC_MAX;
   wire minWrap = live_reg.min == SEC_MAX;
   wire hrWrap = live_reg.hr == HR_MAX;
   wire dateWrap = live_reg.date == lastDay;
   wire monWrap = live_reg.mon == MON_MAX;
   wire yrWrap = live_reg.yr == YR_MAX;

   // Writes win over counting; all fields but control count in BCD
   always_comb begin
      live_next = live_reg;
      if (wr.en) begin
         case (wr.idx)
            IDX_SEC: live_next.sec = wr.data;
            IDX_MIN: live_next.min = wr.data;
            IDX_HR: live_next.hr = wr.data;
            IDX_DATE: live_next.date = wr.data;
            IDX_MON: live_next.mon = wr.data;
            IDX_DAY: live_next.day = wr.data;
            IDX_YR: live_next.yr = wr.data;
            IDX_CTL: live_next.ctl = wr.data & CTL_MASK;
            IDX_CENT: live_next.cent = wr.data;
            default: live_next = live_reg;
         endcase
      end else if (secTick) begin
         live_next.sec = secWrap ? 8'h00 : bcdInc(live_reg.sec);
         if (secWrap) begin
            live_next.min = minWrap ? 8'h00 : bcdInc(live_reg.min);
            if (minWrap) begin
               live_next.hr = hrWrap ? 8'h00 : bcdInc(live_reg.hr);
               if (hrWrap) begin
                  live_next.day = (live_reg.day == DAY_MAX) ? FIRST_ONE : bcdInc(live_reg.day);
                  live_next.date = dateWrap ? FIRST_ONE : bcdInc(live_reg.date);
                  if (dateWrap) begin
                     live_next.mon = monWrap ? FIRST_ONE : bcdInc(live_reg.mon);
                     if (monWrap) begin
                        live_next.yr = yrWrap ? 8'h00 : bcdInc(live_reg.yr);
                        if (yrWrap) begin
                           live_next.cent = bcdInc(live_reg.cent);
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // Snapshot held off past a seconds update so reads stay coherent
   wire take = (capture || pend_reg) && !secTick;

   // Read mux: time from the snapshot, control from live state
   always_comb begin
      case (rdIdx)
         IDX_SEC: rdData_next = snap_reg.sec;
         IDX_MIN: rdData_next = snap_reg.min;
         IDX_HR: rdData_next = snap_reg.hr;
         IDX_DATE: rdData_next = snap_reg.date;
         IDX_MON: rdData_next = snap_reg.mon;
         IDX_DAY: rdData_next = snap_reg.day;
         IDX_YR: rdData_next = snap_reg.yr;
         IDX_CTL: rdData_next = live_reg.ctl;
         IDX_CENT: rdData_next = snap_reg.cent;
         default: rdData_next = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         live_reg <= '{8'h00, 8'h00, 8'h00, FIRST_ONE, FIRST_ONE, FIRST_ONE,
                       YR_POR, 8'h00, CENT_POR};
         snap_reg <= '0;
         pend_reg <= 1'b0;
         rdData <= 8'h00;
      end else begin
         live_reg <= live_next;
         pend_reg <= (capture || pend_reg) && secTick;
         rdData <= rdData_next;
         if (take) begin
            snap_reg <= live_reg;
         end
      end
   end
   assign timeNow = live_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_snap_hold: assert property (!$past(take) |-> $stable(snap_reg))
      else $error("snapshot moved without capture");
   a_snap_defer: assert property (capture && secTick |=> take ##1 snap_reg == $past(live_reg))
      else $error("capture lost at seconds update");
   a_date_wrap: assert property ($changed(live_reg.date) && !$past(wr.en)
      && $past(dateWrap) |-> live_reg.date == FIRST_ONE)
      else $error("month end not applied");
   a_bcd_sec: assert property ($changed(live_reg.sec) && !$past(wr.en)
      |-> live_reg.sec[3:0] <= 4'h9 && live_reg.sec[7:4] <= 4'h5)
      else $error("seconds not BCD");
endmodule : rtcsp_calendar
`default_nettype wire

// ===== bench/rtcsp_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsp_bus_master (
   // Clock
   input wire logic sys_clk,
   // Device data drive
   input wire logic sdaOe,
   input wire logic sdaOut,
   // Bus lines
   output logic sclLine,
   output logic sdaLine
);
   logic sclDrv = 1'b1;
   logic sdaDrv = 1'b1;
   int stepLen = 8;
   // Wired line with pull-up, a released line reads high
   assign sclLine = sclDrv;
   assign sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
   task automatic waitClk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : waitClk
   // Start from idle, or repeated start with clock low
   task automatic start();
      sdaDrv <= 1'b1;
      waitClk(3);
      sclDrv <= 1'b1;
      waitClk(stepLen);
      sdaDrv <= 1'b0;
      waitClk(stepLen);
      sclDrv <= 1'b0;
      waitClk(3);
   endtask : start
   task automatic stop();
      sdaDrv <= 1'b0;
      waitClk(stepLen);
      sclDrv <= 1'b1;
      waitClk(stepLen);
      sdaDrv <= 1'b1;
      waitClk(stepLen);
   endtask : stop
   // Data set in low phase, held through high phase
   task automatic bitCycle(input logic b, output logic s);
      sdaDrv <= b;
      waitClk(stepLen);
      sclDrv <= 1'b1;
      waitClk(stepLen);
      s = sdaLine;
      sclDrv <= 1'b0;
      waitClk(3);
   endtask : bitCycle
   task automatic sendByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(v[i], s);
      end
      bitCycle(1'b1, s);
      ack = ~s;
   endtask : sendByte
   // Low ack asks for more, high ack ends the read
   task automatic readByte(input logic more, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(1'b1, v[i]);
      end
      bitCycle(~more, s);
   endtask : readByte
endmodule : rtcsp_bus_master
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rtcsp_pkg::*;
   localparam logic [6:0] OWN_ID = 7'h2A; // Arbitrary value
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic secToggle = 1'b0;
   logic sclLine, sdaLine, sdaOut, sdaOe, busBusy, writeProtect, a;
   rtcsp_time_t timeNow;
   logic [7:0] ram[32];
   logic [7:0] clk[32];
   logic [7:0] dq[$];
   logic [7:0] rd;
   int n_fail = 0;
   int checks = 0;
   int seed = 19;
   int idx, n;
   always #2 sys_clk = ~sys_clk;
   rtcsp_serial_slave #(.SLAVE_ID(OWN_ID), .RAM_DEPTH(31)) u_rtcsp_serial_slave (
      .sys_clk(sys_clk), .reset_n(reset_n), .sclIn(sclLine), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .secToggle(secToggle), .timeNow(timeNow),
      .busBusy(busBusy), .writeProtect(writeProtect));
   rtcsp_bus_master u_rtcsp_bus_master (.sys_clk(sys_clk), .sdaOe(sdaOe),
      .sdaOut(sdaOut), .sclLine(sclLine), .sdaLine(sdaLine));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Frame opening: identifier then command, both acknowledged
   task automatic openFrame(input logic [7:0] cmd);
      u_rtcsp_bus_master.start();
      u_rtcsp_bus_master.sendByte({OWN_ID, 1'b0}, a);
      check(a, 8'h01);
      check(busBusy, 8'h01);
      u_rtcsp_bus_master.sendByte(cmd, a);
      check(a, 8'h01);
   endtask : openFrame
   // Writes dq from the command index; model follows space, protect and wrap
   task automatic wrSeq(input logic [7:0] cmd);
      int i;
      i = cmd[5:1];
      openFrame(cmd);
      foreach (dq[k]) begin
         u_rtcsp_bus_master.sendByte(dq[k], a);
         check(a, 8'h01);
         if (cmd[7] && cmd[6] && i != 31) ram[i] = dq[k];
         if (cmd[7] && !cmd[6] && (!clk[IDX_CTL][WP_BIT] || i == 7))
            clk[i] = (i == 7) ? dq[k] & CTL_MASK : dq[k];
         i = (i + 1) % 32;
      end
      u_rtcsp_bus_master.stop();
   endtask : wrSeq
   task automatic rdSeq(input logic [7:0] cmd, input int n);
      logic [7:0] v;
      int i;
      i = cmd[5:1];
      openFrame(cmd);
      for (int k = 0; k < n; k++) begin
         u_rtcsp_bus_master.readByte(k < n - 1, v);
         check(v, cmd[6] ? ram[i] : clk[i]);
         i = (i + 1) % 32;
      end
      u_rtcsp_bus_master.stop();
      check(sdaOe, 8'h00);
      check(busBusy, 8'h00);
   endtask : rdSeq
   task automatic chkTime();
      for (int k = 0; k < 8; k++) begin
         check(timeNow[71 - 8 * k -: 8], clk[k]);
      end
      check(timeNow.cent, clk[IDX_CENT]);
   endtask : chkTime
   // Run needs about 26k cycles; a hang stops at over twice that
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_fail++;
      end_of_test();
   end
   // Main sequence
   initial begin
      foreach (ram[k]) ram[k] = 8'h00;
      foreach (clk[k]) clk[k] = 8'h00;
      dq = {8'h00, 8'h00, 8'h00, FIRST_ONE, FIRST_ONE, FIRST_ONE, YR_POR};
      foreach (dq[k]) clk[k] = dq[k];
      clk[IDX_CENT] = CENT_POR;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chkTime();
      check(sdaOe, 8'h00);
      $display("test reset done");
      // Foreign and general call identifiers are ignored
      for (int r = 0; r < 2; r++) begin
         u_rtcsp_bus_master.start();
         u_rtcsp_bus_master.sendByte({r ? GEN_CALL_ID : OWN_ID ^ 7'h01, 1'b0}, a);
         check(a, 8'h00);
         u_rtcsp_bus_master.sendByte(8'hC4, a);
         check(a, 8'h00);
         u_rtcsp_bus_master.stop();
         check(busBusy, 8'h00);
      end
      $display("test refuse done");
      // Random scratch bursts, slow master later, last one wraps past 31
      for (int k = 0; k < 6; k++) begin
         u_rtcsp_bus_master.stepLen = (k < 3) ? 8 : 20;
         idx = (k == 5) ? 30 : $unsigned($random(seed)) % 29;
         n = (k == 5) ? 3 : 1 + $unsigned($random(seed)) % 3;
         dq = {};
         repeat (n) dq.push_back(8'($random(seed)));
         wrSeq({2'b11, idx[4:0], 1'b0});
         rdSeq({2'b11, idx[4:0], 1'b1}, n);
      end
      u_rtcsp_bus_master.stepLen = 8;
      $display("test scratch done");
      // Top command bit low blocks the write
      dq = {8'hA5, 8'h3C};
      wrSeq(8'hC4);
      dq = {8'h5A};
      wrSeq(8'h44);
      rdSeq(8'hC5, 1);
      // Partial byte ended by stop, then by repeated start
      for (int r = 0; r < 2; r++) begin
         openFrame(8'hC4);
         repeat (4) u_rtcsp_bus_master.bitCycle(1'b0, a);
         if (r == 0) u_rtcsp_bus_master.stop();
         rdSeq(8'hC5, 1);
      end
      // Read bit in the identifier reads on from the index left by the last read
      u_rtcsp_bus_master.start();
      u_rtcsp_bus_master.sendByte({OWN_ID, 1'b1}, a);
      check(a, 8'h01);
      u_rtcsp_bus_master.readByte(1'b0, rd);
      u_rtcsp_bus_master.stop();
      check(rd, ram[3]);
      $display("test abort done");
      // Calendar rollover on one tick at a short February
      dq = {SEC_MAX, SEC_MAX, HR_MAX, LAST_28, MON_FEB, DAY_MAX, 8'h01};
      wrSeq(8'h80);
      secToggle <= ~secToggle;
      repeat (20) @(posedge sys_clk);
      dq = {8'h00, 8'h00, 8'h00, FIRST_ONE, 8'h03, FIRST_ONE, 8'h01};
      foreach (dq[k]) clk[k] = dq[k];
      chkTime();
      clk[0] = 8'h01;
      // Tick lands on the last command bit; the latch must wait and see it
      fork
         rdSeq(8'h81, 8);
         begin
            repeat (18) @(negedge sclLine);
            secToggle <= ~secToggle;
         end
      join
      // Write protect blocks clock writes but not the control byte
      dq = {CTL_MASK};
      wrSeq(8'h8E);
      check(writeProtect, 8'h01);
      dq = {8'h33};
      wrSeq(8'h80);
      rdSeq(8'h81, 1);
      dq = {8'h00};
      wrSeq(8'h8E);
      check(writeProtect, 8'h00);
      $display("test calendar done");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
